// *** logic/hbps_regs.vh ***
/*
 Constants of the half-bridge PWM sequencer: register offsets,
 field positions, reset values and timing figures.
 Assumes includers use the bare file name.
*/
`ifndef HBPS_REGS_VH
`define HBPS_REGS_VH
`define HBPS_AW 12
`define HBPS_CTRL_OFS 12'h000
`define HBPS_STAT_OFS 12'h004
`define HBPS_CTRL_EN_BIT 0
`define HBPS_CTRL_RST 1'h1
`define HBPS_ST_LS_BIT 0
`define HBPS_ST_HS_BIT 1
`define HBPS_ST_FSM_LSB 2
`define HBPS_ST_PAR_BIT 5
`define HBPS_ST_OCP_LSB 6
`define HBPS_ST_DIS_BIT 8
`define HBPS_ST_UVLO_BIT 9
`define HBPS_ST_SRC_BIT 10
`define HBPS_ST_OSC_BIT 11
`define HBPS_CLK_NS 10
`define HBPS_TDLY_NS 125
`define HBPS_TDMIN_NS 325
`define HBPS_PRECHG_CYC 10
`endif

// *** logic/hbps_apb.v ***
/*
 APB slave holding the control register and returning the status word.
 Assumes a standard APB master on pclk; zero wait states.
*/
`timescale 1ns/100ps
`include "hbps_regs.vh"
module hbps_apb (
  input wire pclk, // Clock
  input wire presetn, // Async reset, low
  input wire psel, // Select
  input wire penable, // Access phase
  input wire pwrite, // Write
  input wire [`HBPS_AW-1:0] paddr, // Byte address
  input wire [31:0] pwdata, // Write data
  output reg [31:0] prdata, // Read data
  output wire pready, // Always ready
  output wire pslverr, // Unmapped address
  output reg ctrl_en_r, // Switching enable
  input wire [31:0] status // Live status
);
  wire hit_ctrl = (paddr == `HBPS_CTRL_OFS);
  wire hit_stat = (paddr == `HBPS_STAT_OFS);
  wire access = psel & penable;

  assign pready = 1'b1;
  assign pslverr = access & ~(hit_ctrl | hit_stat);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= `HBPS_CTRL_RST;
      prdata <= 32'h0000_0000;
    end else begin
      if (access & pwrite & hit_ctrl)
        ctrl_en_r <= pwdata[`HBPS_CTRL_EN_BIT];
      if (psel & ~penable & ~pwrite) begin
        if (hit_ctrl)
          prdata <= {31'h0000_0000, ctrl_en_r};
        else if (hit_stat)
          prdata <= status;
        else
          prdata <= 32'h0000_0000;
      end
    end
  end
endmodule // hbps_apb

// *** logic/hbps_deadtime.v ***
/*
 Deadtime timer: waits out the current falling ramp, then a fixed delay,
 and never finishes before a minimum total time.
 Assumes start is a one-cycle pulse and ramp is the oscillator pulse level.
*/
`timescale 1ns/100ps
`include "hbps_regs.vh"
module hbps_deadtime #(
  parameter DLY_CYC = 13,
  parameter MIN_CYC = 33,
  parameter CW = 8
) (
  input wire pclk, // Clock
  input wire presetn, // Async reset, low
  input wire start, // Begin a deadtime
  input wire ramp, // Falling ramp in progress
  output reg done // One-cycle end pulse
);
  reg busy_r;
  reg [CW-1:0] dly_r;
  reg [CW-1:0] tot_r;
  wire dly_ok = (dly_r >= DLY_CYC[CW-1:0]);
  wire tot_ok = (tot_r >= MIN_CYC[CW-1:0]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      dly_r <= {CW{1'b0}};
      tot_r <= {CW{1'b0}};
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        dly_r <= {CW{1'b0}};
        tot_r <= {CW{1'b0}};
      end else if (busy_r) begin
        tot_r <= tot_r + 1'b1;
        // Ramp time first, then the fixed delay
        if (!ramp)
          dly_r <= dly_r + 1'b1;
        // Floor against shoot-through
        if (dly_ok && tot_ok && !ramp) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // hbps_deadtime

// *** logic/hbps_top.v ***
/*
 Half-bridge PWM sequencer: splits oscillator pulses into odd and even,
 drives complementary gate commands with deadtime, bootstrap precharge,
 burst mode, two-strike overcurrent latch with hiccup restart, latched
 disable, adaptive undervoltage threshold and an APB register file.
 Assumes comparator inputs synchronous to pclk; presetn is the power
 reset, supply_ok the active undervoltage comparator.
*/
// Added by the designer: the register offsets and the APB slave port.
// How it works
// - High-side interval ends when the current comparator trips.
// - Terminated high side stays off for the rest of the cycle.
// - Overcurrent comparator input flags abnormal overcurrent to protection logic.
// - First trip warns; clean next cycle idles; second trip stops switching.
// - Overcurrent latch clears only when supply drops below undervoltage threshold.
// - After latch clears, startup source waits for restart level before recharging.
// - Disable input stops switching at once and enters low power.
// - Disable latch resets only on supply undervoltage.
// - While disabled, startup source keeps supply between start and one volt below.
// - Oscillator pulse lasts the whole falling ramp.
// - Toggle sorts pulses into odd and even; switching at half rate.
// - Even pulse turns low side off, high side on after deadtime.
// - Low side turns on a deadtime after high side ends.
// - Odd pulse ends a still-running high side.
// - Startup holds low side on ten oscillator cycles before any high side.
// - Burst resume: first pulse low side, high side after second pulse.
// - Deadtime is falling ramp plus fixed 125 ns delay.
// - Deadtime never under 325 ns.
// - Light load selects the lower undervoltage threshold.
// - Normal threshold back after hysteresis and supply above normal threshold.
// - Burst stop below 1.75 V control, resume above 1.82 V.
`timescale 1ns/100ps
`include "hbps_regs.vh"
module hbps_top #(
  parameter PRECHG_CYC = `HBPS_PRECHG_CYC,
  parameter CW = 8
) (
  input wire pclk, // 100 MHz clock
  input wire presetn, // Async reset, low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [`HBPS_AW-1:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error
  input wire osc_pulse, // Sawtooth falling ramp
  input wire cmp_pwm, // Sense reached programming level
  input wire cmp_ocp, // Sense above 1.5 V
  input wire cmp_dis, // Shutdown sense above 4.5 V
  input wire cmp_burst_stop, // Control below 1.75 V
  input wire cmp_burst_go, // Control above 1.82 V
  input wire cmp_light_lo, // Control below light_load_level
  input wire cmp_light_hi, // Control above level plus hysteresis
  input wire supply_ok, // Supply above active UVLO threshold
  input wire vcc_above_norm, // Supply above normal UVLO threshold
  input wire vcc_ge_start, // Supply at supply_start_level
  input wire vcc_below_hyst, // Supply below start level minus 1 V
  input wire vcc_below_restart, // Supply below restart level
  output reg hs_on_r, // High-side gate command
  output reg ls_on_r, // Low-side gate command
  output reg osc_run_r, // Oscillator enable
  output reg src_on_r, // startup_current_source enable
  output reg dis_latch_r, // Reduced-consumption state
  output reg uvlo_low_r // Lower UVLO threshold selected
);
  // Round a time up to whole clock cycles
  function integer ns2cyc;
    input integer ns;
    begin
      ns2cyc = (ns + `HBPS_CLK_NS - 1) / `HBPS_CLK_NS;
    end
  endfunction

  localparam DLY_CYC = ns2cyc(`HBPS_TDLY_NS);
  localparam MIN_CYC = ns2cyc(`HBPS_TDMIN_NS);

  // Sequencer states
  localparam S_OFF = 3'h0;
  localparam S_PRE = 3'h1;
  localparam S_LS = 3'h2;
  localparam S_DTH = 3'h3;
  localparam S_HS = 3'h4;
  localparam S_DTL = 3'h5;
  localparam S_IDLE = 3'h6;
  localparam S_RES = 3'h7;

  // Protection states
  localparam O_IDLE = 2'h0;
  localparam O_WARN = 2'h1;
  localparam O_LATCH = 2'h2;

  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg osc_d_r;
  reg par_r;
  reg par_nxt;
  reg term_r;
  reg term_nxt;
  reg [CW-1:0] pre_cnt_r;
  reg [CW-1:0] pre_cnt_nxt;
  reg [1:0] ocp_r;
  reg [1:0] ocp_nxt;
  reg wcyc_r;
  reg wcyc_nxt;
  reg rearm_r;
  reg dt_start;
  reg boundary;
  wire dt_done;
  wire ctrl_en;
  wire pulse_rise;
  wire samp;
  wire stop;
  wire even_rise;
  wire odd_rise;
  wire [31:0] status;

  // Pulse start marks each oscillator clock pulse
  assign pulse_rise = osc_pulse & ~osc_d_r;
  assign samp = pulse_rise | ~osc_run_r;
  assign even_rise = pulse_rise & par_r;
  assign odd_rise = pulse_rise & ~par_r;
  // Any stop source drops both gates at once
  assign stop = (ocp_r == O_LATCH) | dis_latch_r | cmp_dis | ~ctrl_en | ~supply_ok;

  assign status = {20'h0_0000, osc_run_r, src_on_r, uvlo_low_r,
                   dis_latch_r, ocp_r, par_r, st_r, hs_on_r, ls_on_r};

  hbps_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl_en_r(ctrl_en),
    .status(status)
  );

  hbps_deadtime #(
    .DLY_CYC(DLY_CYC),
    .MIN_CYC(MIN_CYC),
    .CW(CW)
  ) u_dt (
    .pclk(pclk),
    .presetn(presetn),
    .start(dt_start),
    .ramp(osc_pulse),
    .done(dt_done)
  );

  // Switching sequence
  always @* begin
    st_nxt = st_r;
    par_nxt = par_r;
    term_nxt = term_r;
    pre_cnt_nxt = pre_cnt_r;
    dt_start = 1'b0;
    boundary = 1'b0;
    if (pulse_rise)
      par_nxt = ~par_r;
    case (st_r)
      S_OFF: begin
        if (!stop && !cmp_burst_stop && pulse_rise) begin
          st_nxt = S_PRE;
          pre_cnt_nxt = {CW{1'b0}};
        end
      end
      S_PRE: begin
        if (pulse_rise) begin
          pre_cnt_nxt = pre_cnt_r + 1'b1;
          // Bootstrap charged: this pulse acts as the even one
          if (pre_cnt_r == PRECHG_CYC[CW-1:0] - 1'b1) begin
            st_nxt = S_DTH;
            dt_start = 1'b1;
            par_nxt = 1'b0;
            term_nxt = 1'b0;
            boundary = 1'b1;
          end
        end
      end
      S_LS: begin
        if (samp && cmp_burst_stop) begin
          st_nxt = S_IDLE;
        end else if (even_rise) begin
          st_nxt = S_DTH;
          dt_start = 1'b1;
          par_nxt = 1'b0;
          term_nxt = 1'b0;
          boundary = 1'b1;
        end
      end
      S_DTH: begin
        if (dt_done && !term_r)
          st_nxt = S_HS;
      end
      S_HS: begin
        // Loop, overcurrent or odd pulse ends the interval
        if (cmp_pwm || cmp_ocp || odd_rise) begin
          st_nxt = S_DTL;
          dt_start = 1'b1;
          term_nxt = 1'b1;
        end
      end
      S_DTL: begin
        if (dt_done)
          st_nxt = S_LS;
      end
      S_IDLE: begin
        if (pulse_rise)
          st_nxt = S_RES;
      end
      S_RES: begin
        // Second pulse after resume starts the high side
        if (pulse_rise) begin
          st_nxt = S_DTH;
          dt_start = 1'b1;
          par_nxt = 1'b0;
          term_nxt = 1'b0;
          boundary = 1'b1;
        end
      end
      default: st_nxt = S_OFF;
    endcase
    if (stop && st_r != S_OFF) begin
      st_nxt = S_OFF;
      dt_start = 1'b0;
    end
  end

  // Overcurrent protection
  always @* begin
    ocp_nxt = ocp_r;
    wcyc_nxt = wcyc_r;
    case (ocp_r)
      O_IDLE: begin
        if (cmp_ocp && st_r != S_OFF) begin
          ocp_nxt = O_WARN;
          wcyc_nxt = 1'b0;
        end
      end
      O_WARN: begin
        if (cmp_ocp && wcyc_r)
          ocp_nxt = O_LATCH;
        else if (boundary && wcyc_r)
          ocp_nxt = O_IDLE;
        else if (boundary)
          wcyc_nxt = 1'b1;
      end
      O_LATCH: ocp_nxt = O_LATCH;
      default: ocp_nxt = O_IDLE;
    endcase
    if (!supply_ok)
      ocp_nxt = O_IDLE;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_OFF;
      osc_d_r <= 1'b0;
      par_r <= 1'b0;
      term_r <= 1'b0;
      pre_cnt_r <= {CW{1'b0}};
      ocp_r <= O_IDLE;
      wcyc_r <= 1'b0;
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      osc_d_r <= osc_pulse;
      par_r <= par_nxt;
      term_r <= term_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      ocp_r <= ocp_nxt;
      wcyc_r <= wcyc_nxt;
      hs_on_r <= (st_nxt == S_HS);
      ls_on_r <= (st_nxt == S_PRE) || (st_nxt == S_LS) || (st_nxt == S_RES);
    end
  end

  // Disable latch, oscillator and threshold control
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dis_latch_r <= 1'b0;
      osc_run_r <= 1'b0;
      uvlo_low_r <= 1'b0;
    end else begin
      if (!supply_ok)
        dis_latch_r <= 1'b0;
      else if (cmp_dis)
        dis_latch_r <= 1'b1;
      if (dis_latch_r || cmp_dis || !supply_ok)
        osc_run_r <= 1'b0;
      else if (st_r == S_IDLE) begin
        // Resume holds through the hysteresis band
        if (cmp_burst_go)
          osc_run_r <= 1'b1;
      end else if (st_nxt == S_IDLE)
        osc_run_r <= 1'b0;
      else
        osc_run_r <= 1'b1;
      if (samp && cmp_light_lo)
        uvlo_low_r <= 1'b1;
      else if (samp && cmp_light_hi && vcc_above_norm)
        uvlo_low_r <= 1'b0;
    end
  end

  // Startup current source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_on_r <= 1'b0;
      rearm_r <= 1'b1;
    end else begin
      if (dis_latch_r) begin
        // Keep the disable latch powered
        if (vcc_below_hyst)
          src_on_r <= 1'b1;
        else if (vcc_ge_start)
          src_on_r <= 1'b0;
      end else if (supply_ok) begin
        src_on_r <= 1'b0;
        rearm_r <= 1'b0;
      end else begin
        if (vcc_below_restart)
          rearm_r <= 1'b1;
        if (vcc_ge_start) begin
          src_on_r <= 1'b0;
          rearm_r <= 1'b0;
        end else begin
          src_on_r <= rearm_r | vcc_below_restart;
        end
      end
    end
  end
endmodule // hbps_top

// *** verification/hbps_props.sv ***
/*
 Checker of gate sequencing, deadtime and latches on the sequencer ports.
 Assumes binding to hbps_top, one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module hbps_props (
  input wire pclk, // Clock
  input wire presetn, // Reset, low
  input wire osc_pulse, // Osc pulse
  input wire cmp_pwm, // PWM trip
  input wire cmp_ocp, // OCP trip
  input wire cmp_dis, // Disable trip
  input wire cmp_light_lo, // Light load
  input wire supply_ok, // Supply good
  input wire hs_on_r, // High side
  input wire ls_on_r, // Low side
  input wire osc_run_r, // Osc enable
  input wire dis_latch_r, // Disable latch
  input wire uvlo_low_r // Low UVLO
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] gap_r;
  logic hs_seen_r;
  // Cycles with both gates off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 8'h00;
      hs_seen_r <= 1'h0;
    end else begin
      gap_r <= (hs_on_r || ls_on_r) ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
      hs_seen_r <= hs_seen_r | hs_on_r;
    end
  end
  a_no_overlap: assert property (!(hs_on_r && ls_on_r))
    else $error("both gates on");
  a_dt_hs: assert property ($rose(hs_on_r) |-> gap_r >= 8'h21)
    else $error("short deadtime before high side");
  a_dt_ls: assert property ($rose(ls_on_r) && hs_seen_r |-> gap_r >= 8'h21)
    else $error("short deadtime before low side");
  a_pwm_end: assert property (hs_on_r && cmp_pwm |=> !hs_on_r)
    else $error("high side not ended by pwm trip");
  a_ocp_end: assert property (hs_on_r && cmp_ocp |=> !hs_on_r)
    else $error("high side not ended by ocp trip");
  a_odd_end: assert property (hs_on_r && osc_pulse && !$past(osc_pulse) |=> !hs_on_r)
    else $error("high side survived odd pulse");
  a_hs_latch: assert property ($fell(hs_on_r) |-> !hs_on_r [*8])
    else $error("second high side pulse");
  a_dis_set: assert property (cmp_dis && supply_ok |=> dis_latch_r)
    else $error("disable not latched");
  a_dis_stop: assert property (dis_latch_r |=> !hs_on_r && !ls_on_r)
    else $error("gates on while disabled");
  a_dis_hold: assert property (dis_latch_r && supply_ok |=> dis_latch_r)
    else $error("disable latch lost");
  a_light_sel: assert property ($rose(uvlo_low_r) |-> $past(cmp_light_lo))
    else $error("low threshold without light load");
  a_burst_off: assert property (!osc_run_r && !$past(osc_run_r) |-> !hs_on_r && !ls_on_r)
    else $error("gates on with oscillator stopped");
endmodule // hbps_props

bind hbps_top hbps_props u_hbps_props (
  .pclk(pclk), .presetn(presetn), .osc_pulse(osc_pulse), .cmp_pwm(cmp_pwm),
  .cmp_ocp(cmp_ocp), .cmp_dis(cmp_dis), .cmp_light_lo(cmp_light_lo), .supply_ok(supply_ok),
  .hs_on_r(hs_on_r), .ls_on_r(ls_on_r), .osc_run_r(osc_run_r), .dis_latch_r(dis_latch_r),
  .uvlo_low_r(uvlo_low_r)
);

// *** verification/hbps_hb_drv.sv ***
/*
 Gate driver pair model: gates follow commands after DLY clocks.
 Assumes registered commands on pclk; counts overlapping gates.
*/
`timescale 1ns/100ps
module hbps_hb_drv #(
  parameter DLY = 1
) (
  input wire pclk, // Clock
  input wire hs_cmd, // High-side command
  input wire ls_cmd, // Low-side command
  output logic hs_gate, // High-side gate
  output logic ls_gate, // Low-side gate
  output int shoot_cnt // Overlap cycles
);
  logic [7:0] hs_d = 8'h00;
  logic [7:0] ls_d = 8'h00;
  initial shoot_cnt = 0;
  always @(posedge pclk) begin
    hs_d <= {hs_d[6:0], hs_cmd};
    ls_d <= {ls_d[6:0], ls_cmd};
    if (hs_gate && ls_gate) shoot_cnt <= shoot_cnt + 1;
  end
  assign hs_gate = hs_d[DLY-1];
  assign ls_gate = ls_d[DLY-1];
endmodule // hbps_hb_drv

// *** verification/tb.sv ***
/*
 Self-checking bench of the half-bridge PWM sequencer.
 Assumes design, checker and gate driver model compiled before it.
*/
`timescale 1ns/100ps
module tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, hs_on_r, ls_on_r, osc_run_r, src_on_r, dis_latch_r, uvlo_low_r;
  logic osc_pulse = 1'h0, cmp_pwm = 1'h0, cmp_ocp = 1'h0, cmp_dis = 1'h0, supply_ok = 1'h1;
  logic cmp_burst_stop = 1'h0, cmp_burst_go = 1'h0, cmp_light_lo = 1'h0, cmp_light_hi = 1'h0;
  logic vcc_above_norm = 1'h0, vcc_ge_start = 1'h1, vcc_below_hyst = 1'h0;
  logic vcc_below_restart = 1'h0;
  int miscompares = 0, n_compared = 0, np = 0, cyc = 0, seed = 91, k, n0, shoots;
  always #5 pclk = ~pclk;
  hbps_top u_hbps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pulse(osc_pulse), .cmp_pwm(cmp_pwm), .cmp_ocp(cmp_ocp),
    .cmp_dis(cmp_dis), .cmp_burst_stop(cmp_burst_stop), .cmp_burst_go(cmp_burst_go),
    .cmp_light_lo(cmp_light_lo), .cmp_light_hi(cmp_light_hi), .supply_ok(supply_ok),
    .vcc_above_norm(vcc_above_norm), .vcc_ge_start(vcc_ge_start),
    .vcc_below_hyst(vcc_below_hyst), .vcc_below_restart(vcc_below_restart),
    .hs_on_r(hs_on_r), .ls_on_r(ls_on_r), .osc_run_r(osc_run_r), .src_on_r(src_on_r),
    .dis_latch_r(dis_latch_r), .uvlo_low_r(uvlo_low_r));
  hbps_hb_drv #(.DLY(3)) u_hbps_hb_drv (.pclk(pclk), .hs_cmd(hs_on_r), .ls_cmd(ls_on_r),
    .hs_gate(), .ls_gate(), .shoot_cnt(shoots));
  // Oscillator: 8-cycle ramp every 60 cycles while enabled
  always begin
    @(posedge pclk);
    if (osc_run_r === 1'h1) begin
      osc_pulse <= 1'h1;
      np = np + 1;
      repeat (8) @(posedge pclk);
      osc_pulse <= 1'h0;
      repeat (51) @(posedge pclk);
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  task wrap_up();
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("prdata", e, rd & m);
  endtask
  function logic sig(input int s);
    case (s)
      0: return hs_on_r;
      1: return ls_on_r;
      2: return osc_run_r;
      default: return uvlo_low_r;
    endcase
  endfunction
  task wg(input int s, input logic v);
    for (int i = 0; i < 3000 && sig(s) !== v; i++) @(posedge pclk);
    chk("level_wait", {31'h0, v}, {31'h0, sig(s)});
  endtask
  task trip();
    cmp_ocp <= 1'h1;
    wt(1);
    cmp_ocp <= 1'h0;
    wt(1);
  endtask
  initial begin
    wt(12);
    presetn <= 1'h1;
    wt(1);
    rdc(12'h000, 32'hFFFFFFFF, 32'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    wg(1, 1'h1);
    chk("first_pulse", 1, np);
    wg(0, 1'h1);
    chk("precharge", 11, np);
    wg(0, 1'h0);
    chk("odd_end", 12, np);
    for (k = 0; k < 3; k++) begin
      wg(1, 1'h1);
      wg(1, 1'h0);
      chk("hs_wait", 0, hs_on_r);
      wg(0, 1'h1);
      wt(2 + $unsigned($random(seed)) % 15);
      cmp_pwm <= 1'h1;
      wt(1);
      cmp_pwm <= 1'h0;
      wt(1);
      chk("pwm_end", 0, {hs_on_r, ls_on_r});
    end
    wg(0, 1'h1);
    trip();
    rdc(12'h004, 32'hC0, 32'h40);
    wg(0, 1'h1);
    wg(0, 1'h0);
    wg(0, 1'h1);
    rdc(12'h004, 32'hC0, 32'h0);
    trip();
    wg(0, 1'h1);
    trip();
    rdc(12'h004, 32'hC0, 32'h80);
    wt(300);
    chk("ocp_stop", 0, {hs_on_r, ls_on_r});
    supply_ok <= 1'h0;
    vcc_ge_start <= 1'h0;
    wt(5);
    rdc(12'h004, 32'hC0, 32'h0);
    chk("src_wait", 0, src_on_r);
    vcc_below_restart <= 1'h1;
    wt(3);
    chk("src_on", 1, src_on_r);
    vcc_below_restart <= 1'h0;
    vcc_ge_start <= 1'h1;
    supply_ok <= 1'h1;
    wt(3);
    chk("src_off", 0, src_on_r);
    wg(0, 1'h1);
    wg(1, 1'h1);
    cmp_burst_stop <= 1'h1;
    wg(2, 1'h0);
    chk("burst_idle", 0, {hs_on_r, ls_on_r});
    cmp_burst_stop <= 1'h0;
    cmp_burst_go <= 1'h1;
    wg(2, 1'h1);
    n0 = np;
    cmp_burst_go <= 1'h0;
    wg(1, 1'h1);
    chk("resume_ls", n0 + 1, np);
    wg(0, 1'h1);
    chk("resume_hs", n0 + 2, np);
    cmp_light_lo <= 1'h1;
    wg(3, 1'h1);
    cmp_light_lo <= 1'h0;
    cmp_light_hi <= 1'h1;
    wt(150);
    chk("uvlo_hold", 1, uvlo_low_r);
    vcc_above_norm <= 1'h1;
    wg(3, 1'h0);
    wg(0, 1'h1);
    cmp_dis <= 1'h1;
    wt(1);
    cmp_dis <= 1'h0;
    wt(3);
    chk("dis_stop", 32'h1, {hs_on_r, ls_on_r, dis_latch_r});
    vcc_ge_start <= 1'h0;
    vcc_below_hyst <= 1'h1;
    wt(200);
    chk("dis_src", 3, {dis_latch_r, src_on_r});
    vcc_below_hyst <= 1'h0;
    wt(3);
    chk("src_hyst", 1, src_on_r);
    vcc_ge_start <= 1'h1;
    wt(3);
    chk("src_top", 0, src_on_r);
    supply_ok <= 1'h0;
    wt(3);
    chk("dis_clear", 0, dis_latch_r);
    supply_ok <= 1'h1;
    apb(1'h1, 12'h000, $random(seed) & 32'hFFFFFFFE);
    rdc(12'h000, 32'h1, 32'h0);
    wt(100);
    chk("ctrl_off", 0, {hs_on_r, ls_on_r});
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h000, 32'h1);
    rdc(12'h000, 32'h1, 32'h1);
    chk("shoot", 0, shoots);
    wrap_up();
  end
endmodule // tb
